//--- verilog/bsfu_pkg.sv
package bsfu_pkg;
    // Status register bit positions.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Register port map.
    localparam logic [3:0] STATUS_OFF = 4'h0;
    localparam logic [7:0] STATUS_RST = 8'h00;

    // Cycle counts per instruction class.
    localparam int CYC_ONE = 1;
    localparam int CYC_TWO = 2;

    typedef enum logic [4:0] {
        OP_BRANCH_OVERFLOW_CLEAR = 5'h00,
        OP_BRANCH_IRQ_ENABLED = 5'h01,
        OP_BRANCH_IRQ_DISABLED = 5'h02,
        OP_SET_IO_BIT = 5'h03,
        OP_CLEAR_IO_BIT = 5'h04,
        OP_LOGICAL_SHIFT_LEFT = 5'h05,
        OP_LOGICAL_SHIFT_RIGHT = 5'h06,
        OP_ROTATE_LEFT_CARRY = 5'h07,
        OP_ROTATE_RIGHT_CARRY = 5'h08,
        OP_ARITH_SHIFT_RIGHT = 5'h09,
        OP_SWAP_NIBBLES = 5'h0a,
        OP_FLAG_SET_OP = 5'h0b,
        OP_FLAG_CLEAR_OP = 5'h0c,
        OP_STORE_BIT_TO_TRANSFER = 5'h0d,
        OP_LOAD_BIT_FROM_TRANSFER = 5'h0e,
        OP_SET_CARRY = 5'h0f,
        OP_CLEAR_CARRY = 5'h10
    } bsfu_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_HOLD = 2'b10
    } bsfu_state_e;

    typedef struct packed {
        bsfu_state_e state;
        logic hold_io;
        logic busy;
        logic done;
        logic [15:0] pc;
        logic pc_load;
        logic [4:0] io_addr;
        logic [7:0] io_data;
        logic io_wr;
        logic [4:0] rd_addr;
        logic [7:0] rd_data;
        logic rd_wr;
        logic [7:0] status;
        logic [7:0] rdata;
    } bsfu_regs_s;

    localparam bsfu_regs_s REGS_RST = '{
        state: ST_IDLE,
        hold_io: 1'b0,
        busy: 1'b0,
        done: 1'b0,
        pc: 16'h0000,
        pc_load: 1'b0,
        io_addr: 5'h00,
        io_data: 8'h00,
        io_wr: 1'b0,
        rd_addr: 5'h00,
        rd_data: 8'h00,
        rd_wr: 1'b0,
        status: STATUS_RST,
        rdata: 8'h00
    };
endpackage : bsfu_pkg

//--- verilog/bsfu_unit.sv
// How it works
// [RL1] Branch when overflow clear: PC plus k plus one.
// [RL2] Branch when interrupts enabled, flags untouched.
// [RL3] Branch when interrupts disabled, flags untouched.
// [RL4] Set chosen I/O bit, two cycles.
// [RL5] Clear chosen I/O bit, two cycles.
// [RL6] Shift left, zero in, four flags.
// [RL7] Shift right, zero in, four flags.
// [RL8] Rotate left through carry, four flags.
// [RL9] Rotate right through carry, four flags.
// [RL10] Arithmetic right shift keeps sign bit.
// [RL11] Copy register bit into transfer flag.
// [RL12] Copy transfer flag into register bit.
// [RL13] Swap nibbles, no flag changes.
// [RL14] Set or clear chosen status bit; carry variants.
`timescale 1ns/10ps
module bsfu_unit (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Instruction from the decoder.
    input wire logic op_valid_i,
    input wire bsfu_pkg::bsfu_op_e op_i,
    input wire logic [7:0] opd_i,
    input wire logic [4:0] rd_addr_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [6:0] offset_i,
    input wire logic [15:0] pc_i,
    input wire logic [4:0] io_addr_i,
    input wire logic [7:0] io_data_i,
    // Completion and results.
    output logic busy_o,
    output logic done_o,
    output logic [15:0] pc_o,
    output logic pc_load_o,
    output logic [4:0] io_addr_o,
    output logic [7:0] io_data_o,
    output logic io_wr_o,
    output logic [4:0] rd_addr_o,
    output logic [7:0] rd_data_o,
    output logic rd_wr_o,
    output logic [7:0] status_o,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);

    bsfu_pkg::bsfu_regs_s r;
    bsfu_pkg::bsfu_regs_s next_r;
    logic op_take;
    logic [15:0] br_target;
    logic [7:0] bit_mask;
    logic [7:0] sh_res;
    logic sh_cy;
    logic is_shift;

    assign op_take = op_valid_i && (r.state == bsfu_pkg::ST_IDLE);
    assign br_target = pc_i + {{9{offset_i[6]}}, offset_i} + 16'h0001;
    assign bit_mask = 8'h01 << bit_sel_i;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.io_wr = 1'b0;
        next_r.rd_wr = 1'b0;
        next_r.rdata = 8'h00;
        sh_res = 8'h00;
        sh_cy = 1'b0;
        is_shift = 1'b0;
        if (reg_rd_i && reg_addr_i == bsfu_pkg::STATUS_OFF) begin
            next_r.rdata = r.status;
        end
        // A software write lands first; an instruction's flag update then overrides the bits it owns.
        if (reg_wr_i && reg_addr_i == bsfu_pkg::STATUS_OFF) begin
            next_r.status = reg_wdata_i;
        end
        unique case (r.state)
            bsfu_pkg::ST_HOLD: begin
                next_r.state = bsfu_pkg::ST_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                if (r.hold_io) begin
                    next_r.io_wr = 1'b1; // see [RL4] see [RL5]
                end else begin
                    next_r.pc_load = 1'b1; // see [RL1] see [RL2] see [RL3]
                end
            end
            bsfu_pkg::ST_IDLE: begin
                if (op_take) begin
                    next_r.done = 1'b1;
                    next_r.rd_addr = rd_addr_i;
                    unique case (op_i)
                        bsfu_pkg::OP_BRANCH_OVERFLOW_CLEAR,
                        bsfu_pkg::OP_BRANCH_IRQ_ENABLED,
                        bsfu_pkg::OP_BRANCH_IRQ_DISABLED: begin
                            next_r.pc = br_target;
                            if ((op_i == bsfu_pkg::OP_BRANCH_OVERFLOW_CLEAR && !r.status[bsfu_pkg::FLAG_V]) ||
                                (op_i == bsfu_pkg::OP_BRANCH_IRQ_ENABLED && r.status[bsfu_pkg::FLAG_I]) ||
                                (op_i == bsfu_pkg::OP_BRANCH_IRQ_DISABLED && !r.status[bsfu_pkg::FLAG_I])) begin
                                // A taken branch spends a second cycle before the PC load.
                                next_r.state = bsfu_pkg::ST_HOLD; // see [RL1] see [RL2] see [RL3]
                                next_r.busy = 1'b1;
                                next_r.hold_io = 1'b0;
                                next_r.done = 1'b0;
                            end
                        end
                        bsfu_pkg::OP_SET_IO_BIT,
                        bsfu_pkg::OP_CLEAR_IO_BIT: begin
                            next_r.io_addr = io_addr_i;
                            if (op_i == bsfu_pkg::OP_SET_IO_BIT) begin
                                next_r.io_data = io_data_i | bit_mask; // see [RL4]
                            end else begin
                                next_r.io_data = io_data_i & ~bit_mask; // see [RL5]
                            end
                            next_r.state = bsfu_pkg::ST_HOLD;
                            next_r.busy = 1'b1;
                            next_r.hold_io = 1'b1;
                            next_r.done = 1'b0;
                        end
                        bsfu_pkg::OP_LOGICAL_SHIFT_LEFT: begin
                            sh_res = {opd_i[6:0], 1'b0}; // see [RL6]
                            sh_cy = opd_i[7];
                            is_shift = 1'b1;
                        end
                        bsfu_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
                            sh_res = {1'b0, opd_i[7:1]}; // see [RL7]
                            sh_cy = opd_i[0];
                            is_shift = 1'b1;
                        end
                        bsfu_pkg::OP_ROTATE_LEFT_CARRY: begin
                            sh_res = {opd_i[6:0], r.status[bsfu_pkg::FLAG_C]}; // see [RL8]
                            sh_cy = opd_i[7];
                            is_shift = 1'b1;
                        end
                        bsfu_pkg::OP_ROTATE_RIGHT_CARRY: begin
                            sh_res = {r.status[bsfu_pkg::FLAG_C], opd_i[7:1]}; // see [RL9]
                            sh_cy = opd_i[0];
                            is_shift = 1'b1;
                        end
                        bsfu_pkg::OP_ARITH_SHIFT_RIGHT: begin
                            sh_res = {opd_i[7], opd_i[7:1]}; // see [RL10]
                            sh_cy = opd_i[0];
                            is_shift = 1'b1;
                        end
                        bsfu_pkg::OP_SWAP_NIBBLES: begin
                            next_r.rd_data = {opd_i[3:0], opd_i[7:4]}; // see [RL13]
                            next_r.rd_wr = 1'b1;
                        end
                        bsfu_pkg::OP_FLAG_SET_OP: begin
                            next_r.status[bit_sel_i] = 1'b1; // see [RL14]
                        end
                        bsfu_pkg::OP_FLAG_CLEAR_OP: begin
                            next_r.status[bit_sel_i] = 1'b0; // see [RL14]
                        end
                        bsfu_pkg::OP_STORE_BIT_TO_TRANSFER: begin
                            next_r.status[bsfu_pkg::FLAG_T] = opd_i[bit_sel_i]; // see [RL11]
                        end
                        bsfu_pkg::OP_LOAD_BIT_FROM_TRANSFER: begin
                            next_r.rd_data = r.status[bsfu_pkg::FLAG_T] ?
                                (opd_i | bit_mask) : (opd_i & ~bit_mask); // see [RL12]
                            next_r.rd_wr = 1'b1;
                        end
                        bsfu_pkg::OP_SET_CARRY: begin
                            next_r.status[bsfu_pkg::FLAG_C] = 1'b1; // see [RL14]
                        end
                        bsfu_pkg::OP_CLEAR_CARRY: begin
                            next_r.status[bsfu_pkg::FLAG_C] = 1'b0; // see [RL14]
                        end
                        default: begin
                            // Undefined codes retire in one cycle and change nothing but the latched rd_addr.
                            next_r.done = 1'b1;
                        end
                    endcase
                    if (is_shift) begin
                        // Overflow follows the usual N xor C convention for shifts.
                        next_r.rd_data = sh_res; // see [RL6] see [RL7] see [RL8] see [RL9] see [RL10]
                        next_r.rd_wr = 1'b1;
                        next_r.status[bsfu_pkg::FLAG_Z] = (sh_res == 8'h00);
                        next_r.status[bsfu_pkg::FLAG_C] = sh_cy;
                        next_r.status[bsfu_pkg::FLAG_N] = sh_res[7];
                        next_r.status[bsfu_pkg::FLAG_V] = sh_res[7] ^ sh_cy;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            r <= bsfu_pkg::REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    assign busy_o = r.busy;
    assign done_o = r.done;
    assign pc_o = r.pc;
    assign pc_load_o = r.pc_load;
    assign io_addr_o = r.io_addr;
    assign io_data_o = r.io_data;
    assign io_wr_o = r.io_wr;
    assign rd_addr_o = r.rd_addr;
    assign rd_data_o = r.rd_data;
    assign rd_wr_o = r.rd_wr;
    assign status_o = r.status;
    assign reg_rdata_o = r.rdata;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_br_vc;  // see [RL1]
        op_take && op_i == bsfu_pkg::OP_BRANCH_OVERFLOW_CLEAR && !status_o[bsfu_pkg::FLAG_V]
        |=> busy_o && !done_o ##1 pc_load_o && done_o && pc_o == $past(br_target, 2);
    endproperty
    a_br_vc: assert property (p_br_vc) else $error("overflow-clear branch wrong"); // see [RL1]

    property p_br_ie;  // see [RL2]
        op_take && op_i == bsfu_pkg::OP_BRANCH_IRQ_ENABLED
        |=> ((status_o == $past(status_o) || $past(reg_wr_i)) and
            (if (!$past(status_o[bsfu_pkg::FLAG_I])) (done_o && !pc_load_o) else (busy_o ##1 pc_load_o)));
    endproperty
    a_br_ie: assert property (p_br_ie) else $error("irq-enabled branch wrong"); // see [RL2]

    property p_br_id;  // see [RL3]
        op_take && op_i == bsfu_pkg::OP_BRANCH_IRQ_DISABLED && status_o[bsfu_pkg::FLAG_I]
        |=> done_o && !pc_load_o && !busy_o;
    endproperty
    a_br_id: assert property (p_br_id) else $error("irq-disabled branch taken wrongly"); // see [RL3]

    property p_set_io;  // see [RL4]
        op_take && op_i == bsfu_pkg::OP_SET_IO_BIT
        |=> !io_wr_o ##1 io_wr_o && done_o && io_data_o == ($past(io_data_i, 2) | $past(bit_mask, 2));
    endproperty
    a_set_io: assert property (p_set_io) else $error("set io bit wrong"); // see [RL4]

    property p_clr_io;  // see [RL5]
        op_take && op_i == bsfu_pkg::OP_CLEAR_IO_BIT
        |=> !io_wr_o ##1 io_wr_o && io_addr_o == $past(io_addr_i, 2) &&
            io_data_o == ($past(io_data_i, 2) & ~$past(bit_mask, 2));
    endproperty
    a_clr_io: assert property (p_clr_io) else $error("clear io bit wrong"); // see [RL5]

    property p_lsl;  // see [RL6]
        op_take && op_i == bsfu_pkg::OP_LOGICAL_SHIFT_LEFT
        |=> rd_wr_o && rd_data_o == {$past(opd_i[6:0]), 1'b0} && status_o[bsfu_pkg::FLAG_C] == $past(opd_i[7]);
    endproperty
    a_lsl: assert property (p_lsl) else $error("shift left wrong"); // see [RL6]

    property p_lsr;  // see [RL7]
        op_take && op_i == bsfu_pkg::OP_LOGICAL_SHIFT_RIGHT
        |=> rd_data_o == {1'b0, $past(opd_i[7:1])} && !status_o[bsfu_pkg::FLAG_N] &&
            status_o[bsfu_pkg::FLAG_V] == status_o[bsfu_pkg::FLAG_C];
    endproperty
    a_lsr: assert property (p_lsr) else $error("shift right wrong"); // see [RL7]

    property p_rol;  // see [RL8]
        op_take && op_i == bsfu_pkg::OP_ROTATE_LEFT_CARRY
        |=> rd_data_o == {$past(opd_i[6:0]), $past(status_o[bsfu_pkg::FLAG_C])} &&
            status_o[bsfu_pkg::FLAG_Z] == (rd_data_o == 8'h00);
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong"); // see [RL8]

    property p_ror;  // see [RL9]
        op_take && op_i == bsfu_pkg::OP_ROTATE_RIGHT_CARRY
        |=> rd_data_o == {$past(status_o[bsfu_pkg::FLAG_C]), $past(opd_i[7:1])} &&
            status_o[bsfu_pkg::FLAG_C] == $past(opd_i[0]);
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong"); // see [RL9]

    property p_asr;  // see [RL10]
        op_take && op_i == bsfu_pkg::OP_ARITH_SHIFT_RIGHT
        |=> rd_data_o == {$past(opd_i[7]), $past(opd_i[7:1])} && status_o[bsfu_pkg::FLAG_N] == $past(opd_i[7]);
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic shift wrong"); // see [RL10]

    property p_bst;  // see [RL11]
        op_take && op_i == bsfu_pkg::OP_STORE_BIT_TO_TRANSFER
        |=> done_o && status_o[bsfu_pkg::FLAG_T] == $past(opd_i[bit_sel_i]);
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong"); // see [RL11]

    property p_bld;  // see [RL12]
        op_take && op_i == bsfu_pkg::OP_LOAD_BIT_FROM_TRANSFER
        |=> rd_wr_o && ((rd_data_o ^ $past(opd_i)) & ~$past(bit_mask)) == 8'h00 &&
            ((rd_data_o & $past(bit_mask)) != 8'h00) == $past(status_o[bsfu_pkg::FLAG_T]);
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong"); // see [RL12]

    property p_swap;  // see [RL13]
        op_take && op_i == bsfu_pkg::OP_SWAP_NIBBLES && !reg_wr_i
        |=> rd_data_o == {$past(opd_i[3:0]), $past(opd_i[7:4])} && $stable(status_o);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong"); // see [RL13]

    property p_flag;  // see [RL14]
        op_take && (op_i == bsfu_pkg::OP_FLAG_SET_OP || op_i == bsfu_pkg::OP_SET_CARRY)
        |=> status_o[$past(op_i == bsfu_pkg::OP_SET_CARRY) ? 3'h0 : $past(bit_sel_i)];
    endproperty
    a_flag: assert property (p_flag) else $error("flag set wrong"); // see [RL14]

    c_taken: cover property (op_take && op_i == bsfu_pkg::OP_BRANCH_IRQ_ENABLED ##2 pc_load_o);
    c_io: cover property (op_take && op_i == bsfu_pkg::OP_SET_IO_BIT ##2 io_wr_o);
    c_rot: cover property (op_take && op_i == bsfu_pkg::OP_ROTATE_LEFT_CARRY ##1 rd_wr_o);
    c_clr: cover property (op_take && op_i == bsfu_pkg::OP_CLEAR_CARRY && reg_wr_i);

endmodule : bsfu_unit

//--- testbench/bsfu_io_model.sv
`timescale 1ns/10ps
module bsfu_io_model (
    // Clock.
    input wire logic clk_sys_i,
    // Read side toward the unit.
    input wire logic [4:0] io_addr_i,
    output logic [7:0] io_data_o,
    // Write-back from the unit.
    input wire logic [4:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i
);
    logic [7:0] io_mem [32];

    // Mixed contents, so that set and clear both meet bits that already hold their new value.
    initial begin
        for (int i = 0; i < 32; i++) begin
            io_mem[i] = 8'(i * 37) ^ 8'h5a;
        end
    end

    // The decoder reads the I/O file in the same cycle as it issues the instruction.
    assign io_data_o = io_mem[io_addr_i];

    always @(posedge clk_sys_i) begin
        if (wr_i) begin
            io_mem[wr_addr_i] <= wr_data_i;
        end
    end
endmodule : bsfu_io_model

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic op_valid_i = 1'b0;
    bsfu_pkg::bsfu_op_e op_i = bsfu_pkg::OP_SET_CARRY;
    logic [7:0] opd_i = 8'h00;
    logic [4:0] rd_addr_i = 5'h00;
    logic [2:0] bit_sel_i = 3'h0;
    logic [6:0] offset_i = 7'h00;
    logic [15:0] pc_i = 16'h0000;
    logic [4:0] io_addr_i = 5'h00;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] io_data_i, io_data_o, rd_data_o, status_o, reg_rdata_o;
    logic [15:0] pc_o;
    logic [4:0] io_addr_o, rd_addr_o;
    logic busy_o, done_o, pc_load_o, io_wr_o, rd_wr_o;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    bsfu_unit dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_i(op_i),
        .opd_i(opd_i), .rd_addr_i(rd_addr_i), .bit_sel_i(bit_sel_i), .offset_i(offset_i), .pc_i(pc_i),
        .io_addr_i(io_addr_i), .io_data_i(io_data_i), .busy_o(busy_o), .done_o(done_o), .pc_o(pc_o),
        .pc_load_o(pc_load_o), .io_addr_o(io_addr_o), .io_data_o(io_data_o), .io_wr_o(io_wr_o),
        .rd_addr_o(rd_addr_o), .rd_data_o(rd_data_o), .rd_wr_o(rd_wr_o), .status_o(status_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o));

    bsfu_io_model far_u (.clk_sys_i(clk_sys_i), .io_addr_i(io_addr_i), .io_data_o(io_data_i),
        .wr_addr_i(io_addr_o), .wr_data_i(io_data_o), .wr_i(io_wr_o));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t ns %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("[FAIL] %0t ns run did not finish", $time);
            report_and_stop();
        end
    end

    // Each register task returns just after the edge that took its strobe.
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : reg_read

    // Presents one instruction for one edge and returns once that edge's results have landed.
    task automatic issue(input bsfu_pkg::bsfu_op_e op, input logic [7:0] opd, input logic [2:0] b,
                         input logic [6:0] k, input logic [15:0] pc, input logic [4:0] ioa);
        @(posedge clk_sys_i);
        op_valid_i <= 1'b1;
        op_i <= op;
        opd_i <= opd;
        rd_addr_i <= opd[4:0];
        bit_sel_i <= b;
        offset_i <= k;
        pc_i <= pc;
        io_addr_i <= ioa;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b0;
        #1;
    endtask : issue

    task automatic test_reg_port;
        logic [7:0] d;
        check(status_o, bsfu_pkg::STATUS_RST, "status after reset");
        reg_read(bsfu_pkg::STATUS_OFF, d);
        check(d, bsfu_pkg::STATUS_RST, "status read after reset");
        reg_write(4'h5, 8'hff);
        check(status_o, bsfu_pkg::STATUS_RST, "unmapped write");
        reg_write(bsfu_pkg::STATUS_OFF, 8'ha5);
        reg_read(bsfu_pkg::STATUS_OFF, d);
        check(d, 8'ha5, "status read back");
        reg_read(4'h5, d);
        check(d, 8'h00, "unmapped read");
        @(posedge clk_sys_i);
        #1;
        check(reg_rdata_o, 8'h00, "read data after its cycle");
        $display("test reg_port done");
    endtask : test_reg_port

    function automatic logic [8:0] shift_exp(input int i, input logic [7:0] a, input logic cin);
        case (i)
            0: return {a[7], a[6:0], 1'b0};
            1: return {a[0], 1'b0, a[7:1]};
            2: return {a[7], a[6:0], cin};
            3: return {a[0], cin, a[7:1]};
            default: return {a[0], a[7], a[7:1]};
        endcase
    endfunction : shift_exp

    task automatic test_shifts;
        logic [7:0] vals [4] = '{8'h81, 8'h00, 8'h7e, 8'h01};
        logic [8:0] e;
        logic [7:0] st;
        for (int i = 0; i < 5; i++) begin
            foreach (vals[j]) begin
                for (int c = 0; c < 2; c++) begin
                    // S and H are set beforehand to show that shifts leave them alone.
                    reg_write(bsfu_pkg::STATUS_OFF, 8'h30 | 8'(c));
                    e = shift_exp(i, vals[j], c[0]);
                    st = 8'h30;
                    st[bsfu_pkg::FLAG_C] = e[8];
                    st[bsfu_pkg::FLAG_Z] = (e[7:0] == 8'h00);
                    st[bsfu_pkg::FLAG_N] = e[7];
                    st[bsfu_pkg::FLAG_V] = e[7] ^ e[8];
                    issue(bsfu_pkg::bsfu_op_e'(bsfu_pkg::OP_LOGICAL_SHIFT_LEFT + i), vals[j], 3'h0, 7'h00,
                          16'h0000, 5'h00);
                    check(rd_data_o, e[7:0], "shift result");
                    check({rd_wr_o, done_o, busy_o, rd_addr_o}, {3'b110, vals[j][4:0]}, "shift strobes");
                    check(status_o, st, "shift flags");
                end
            end
        end
        reg_write(bsfu_pkg::STATUS_OFF, 8'h5a);
        issue(bsfu_pkg::OP_SWAP_NIBBLES, 8'h3c, 3'h0, 7'h00, 16'h0000, 5'h00);
        check(rd_data_o, 8'hc3, "swap result");
        check(status_o, 8'h5a, "swap flags");
        @(posedge clk_sys_i);
        #1;
        check({rd_wr_o, done_o}, 2'b00, "write-back pulse length");
        $display("test shifts done");
    endtask : test_shifts

    task automatic test_branches;
        logic [6:0] k;
        logic [15:0] pc;
        logic [7:0] sv;
        for (int i = 0; i < 3; i++) begin
            for (int t = 0; t < 2; t++) begin
                // The status value makes the branch taken exactly when t is 1.
                sv = (i == 0) ? (t == 1 ? 8'h77 : 8'h7f) : (((i == 1) == (t == 1)) ? 8'h80 : 8'h00);
                k = (i == 0) ? 7'h01 : 7'h40;
                pc = (i == 0) ? 16'hfffe : 16'h0100;
                reg_write(bsfu_pkg::STATUS_OFF, sv);
                issue(bsfu_pkg::bsfu_op_e'(i), 8'h00, 3'h0, k, pc, 5'h00);
                check({busy_o, done_o, pc_load_o}, t == 1 ? 3'b100 : 3'b010, "branch first cycle");
                if (t == 1) begin
                    @(posedge clk_sys_i);
                    #1;
                    check({busy_o, done_o, pc_load_o}, 3'b011, "branch second cycle");
                    check(pc_o, pc + {{9{k[6]}}, k} + 16'h0001, "branch target");
                end
                check(status_o, sv, "branch flags");
            end
        end
        $display("test branches done");
    endtask : test_branches

    task automatic test_io_bits;
        logic [7:0] e;
        logic [4:0] a;
        reg_write(bsfu_pkg::STATUS_OFF, 8'h3c);
        for (int s = 0; s < 2; s++) begin
            for (int b = 0; b < 8; b += 3) begin
                a = 5'(4 * b + s + 1);
                e = (s == 1) ? (far_u.io_mem[a] & ~(8'h01 << b)) : (far_u.io_mem[a] | (8'h01 << b));
                @(posedge clk_sys_i);
                op_valid_i <= 1'b1;
                op_i <= (s == 1) ? bsfu_pkg::OP_CLEAR_IO_BIT : bsfu_pkg::OP_SET_IO_BIT;
                bit_sel_i <= 3'(b);
                io_addr_i <= a;
                @(posedge clk_sys_i);
                // A shift held up during the busy cycle must be dropped.
                op_i <= bsfu_pkg::OP_LOGICAL_SHIFT_LEFT;
                #1;
                check({busy_o, done_o, io_wr_o}, 3'b100, "io first cycle");
                @(posedge clk_sys_i);
                op_valid_i <= 1'b0;
                #1;
                check({busy_o, done_o, io_wr_o, rd_wr_o}, 4'b0110, "io second cycle");
                check({io_addr_o, io_data_o}, {a, e}, "io write-back");
                @(posedge clk_sys_i);
                #1;
                check(far_u.io_mem[a], e, "io register contents");
                check({rd_wr_o, status_o}, {1'b0, 8'h3c}, "dropped op and flags");
            end
        end
        $display("test io_bits done");
    endtask : test_io_bits

    task automatic test_bit_moves;
        logic [7:0] v = 8'ha6;
        logic [7:0] e;
        for (int b = 0; b < 8; b++) begin
            // The transfer flag starts opposite to the bit, so every store flips it.
            reg_write(bsfu_pkg::STATUS_OFF, v[b] ? 8'h00 : 8'h40);
            issue(bsfu_pkg::OP_STORE_BIT_TO_TRANSFER, v, 3'(b), 7'h00, 16'h0000, 5'h00);
            e = 8'h00;
            e[bsfu_pkg::FLAG_T] = v[b];
            check({status_o, done_o}, {e, 1'b1}, "store bit");
            issue(bsfu_pkg::OP_LOAD_BIT_FROM_TRANSFER, ~v, 3'(b), 7'h00, 16'h0000, 5'h00);
            e = ~v;
            e[b] = v[b];
            check({rd_data_o, rd_wr_o}, {e, 1'b1}, "load bit");
        end
        $display("test bit_moves done");
    endtask : test_bit_moves

    task automatic test_flag_ops;
        for (int s = 0; s < 8; s++) begin
            reg_write(bsfu_pkg::STATUS_OFF, 8'h00);
            issue(bsfu_pkg::OP_FLAG_SET_OP, 8'h00, 3'(s), 7'h00, 16'h0000, 5'h00);
            check(status_o, 8'(8'h01 << s), "flag set");
            reg_write(bsfu_pkg::STATUS_OFF, 8'hff);
            issue(bsfu_pkg::OP_FLAG_CLEAR_OP, 8'h00, 3'(s), 7'h00, 16'h0000, 5'h00);
            check(status_o, 8'(~(8'h01 << s)), "flag clear");
        end
        reg_write(bsfu_pkg::STATUS_OFF, 8'hfe);
        issue(bsfu_pkg::OP_SET_CARRY, 8'h00, 3'h5, 7'h00, 16'h0000, 5'h00);
        check(status_o, 8'hff, "carry set");
        issue(bsfu_pkg::OP_CLEAR_CARRY, 8'h00, 3'h5, 7'h00, 16'h0000, 5'h00);
        check(status_o, 8'hfe, "carry clear");
        // An undefined code must retire in one cycle and leave every result but rd_addr_o alone.
        issue(bsfu_pkg::bsfu_op_e'(5'h1f), 8'hff, 3'h0, 7'h00, 16'h0000, 5'h00);
        check({done_o, busy_o, rd_wr_o, io_wr_o, pc_load_o, status_o}, {5'b10000, 8'hfe}, "undefined op");
        $display("test flag_ops done");
    endtask : test_flag_ops

    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        #1;
        test_reg_port();
        test_shifts();
        test_branches();
        test_io_bits();
        test_bit_moves();
        test_flag_ops();
        report_and_stop();
    end
endmodule : testbench
